// File: src/ppcc_pkg.sv
// Package for the capability page CRC checker: offsets, codes, states and carriers
`default_nettype none
package ppcc_pkg;
    localparam int IDX_W = 16;
    // CRC engine
    localparam logic [15:0] CRC_POLY = 16'h8005;
    localparam logic [15:0] CRC_INIT = 16'h4f4e;
    // Capability page layout
    localparam logic [IDX_W-1:0] PG_WARMUP = 16'h009f;
    localparam logic [IDX_W-1:0] PG_DDR3_LO = 16'h00a0;
    localparam logic [IDX_W-1:0] PG_DDR3_HI = 16'h00a1;
    localparam logic [IDX_W-1:0] PG_DDR2_EXT = 16'h00a2;
    localparam logic [IDX_W-1:0] PG_CRC_LAST = 16'h00fd;
    localparam logic [IDX_W-1:0] PG_CRC_LO = 16'h00fe;
    localparam logic [IDX_W-1:0] PG_CRC_HI = 16'h00ff;
    localparam int PG_COPIES = 3;
    // Extended page layout
    localparam logic [IDX_W-1:0] EX_CRC_LO = 16'h0000;
    localparam logic [IDX_W-1:0] EX_CRC_HI = 16'h0001;
    localparam logic [IDX_W-1:0] EX_SIG_FIRST = 16'h0002;
    localparam logic [IDX_W-1:0] EX_SIG_LAST = 16'h0005;
    localparam logic [IDX_W-1:0] EX_PAIR_FIRST = 16'h0010;
    localparam logic [IDX_W-1:0] EX_PAIR_LAST = 16'h001f;
    localparam int EX_UNIT_SHIFT = 4;
    localparam logic [7:0] EX_SIG_B0 = 8'h45;
    localparam logic [7:0] EX_SIG_B1 = 8'h50;
    localparam logic [7:0] EX_SIG_B2 = 8'h50;
    localparam logic [7:0] EX_SIG_B3 = 8'h53;
    localparam logic [2:0] EX_SIG_MIN = 3'h2;
    localparam logic [7:0] SECT_UNUSED = 8'h00;
    localparam logic [7:0] SECT_SPEC = 8'h01;
    localparam logic [7:0] SECT_ECC = 8'h02;

    typedef enum {ST_IDLE, ST_RUN, ST_CHECK, ST_DONE} ppcc_state_t;

    typedef struct packed {
        logic done;
        logic valid;
        logic error;
        logic [1:0] copy;
    } ppcc_result_t;

    typedef struct packed {
        logic [3:0] warm_out;
        logic [3:0] warm_in;
        logic [15:0] ddr3_modes;
        logic [2:0] ddr2_modes;
        logic ddr3_rsvd_err;
        logic ddr2_rsvd_err;
        logic ddr3_gap_err;
        logic ddr2_gap_err;
        logic ddr3_none;
    } ppcc_caps_t;

    typedef struct packed {
        logic sig_ok;
        logic [3:0] sect_count;
        logic has_spec;
        logic has_ecc;
        logic order_err;
        logic len_err;
        logic [IDX_W-1:0] last_idx;
    } ppcc_ext_t;
endpackage : ppcc_pkg
`default_nettype wire

// File: src/ppcc_crc_byte.sv
// Byte-wide CRC register, most significant bit first, no reflection
`default_nettype none
module ppcc_crc_byte
    import ppcc_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic init_i,
    input wire logic en_i,
    input wire logic [7:0] data_i,
    output logic [15:0] crc_o
);
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        logic fb;
        r = c;
        for (int i = 7; i >= 0; i--) begin
            fb = r[15] ^ d[i];
            r = {r[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
        end
        return r;
    endfunction

    wire logic [15:0] crc_next = init_i ? CRC_INIT : (en_i ? crc_step(crc_o, data_i) : crc_o);

    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            crc_o <= CRC_INIT;
        end else begin
            crc_o <= crc_next;
        end
    end
endmodule // ppcc_crc_byte
`default_nettype wire

// File: src/ppcc_checker.sv
// Capability page and extended page checker, with copy fallback for the capability page only
`default_nettype none
// Behaviour
// - Low nibble of byte 159 gives output warmup cycles; zero means none.
// - High nibble of byte 159 gives input warmup cycles; zero means none.
// - Bytes 160-161: bit 0 modes 0-3, bits 1-12 modes 4-15, 13-15 zero.
// - Supported modes form one gapless range; a supported interface flags one.
// - Byte 162 bits 0-2 flag modes 8-10; bits 3-7 zero.
// - Page CRC covers bytes 0-253, stored in 254-255 and compared.
// - CRC takes bytes lowest first, bit 7 down to bit 0.
// - Generator polynomial is 8005h.
// - Preset 4F4Eh, no final XOR, no reflection.
// - Bytes 256-511 copy the page; used when the first copy fails.
// - Bytes 512-767 second copy; used only when both earlier copies fail.
// - Redundant copies come from storage, never a retransmission.
// - Sections are multiples of 16 bytes; types 0,1,2 defined, rest reserved.
// - Nonzero types ascend, each once; type zero ends the walk.
// - Type 1 lists pairs for sections 8 onward when more than eight exist.
// - Type 2 holds 8-byte ECC blocks, block 0 mandatory, rest zero.
// - Header: CRC 0-1, signature 2-5, zeros 6-15, pairs 16-31, data from 32.
// - Multi-byte fields are little-endian.
// - Unused extended page fields should read zero.
// - Extended CRC: same engine, bytes 2 to end, stored in bytes 0-1.
// - Section length counts 16-byte units.
module ppcc_checker
    import ppcc_pkg::*;
#(
    parameter int MAX_COPIES = PG_COPIES
) (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic start_i,
    input wire logic ext_mode_i,
    input wire logic byte_valid_i,
    input wire logic [7:0] byte_data_i,
    output logic byte_ready_o,
    output ppcc_result_t result_o,
    output ppcc_caps_t caps_o,
    output ppcc_ext_t ext_o
);
    // Counts starts of runs of ones; more than one start is a gap
    function automatic logic has_gap(input logic [15:0] v);
        logic [4:0] starts;
        starts = {4'h0, v[0]};
        for (int i = 1; i < 16; i++) begin
            starts = starts + {4'h0, (v[i] & ~v[i-1])};
        end
        return starts > 5'h01;
    endfunction

    function automatic logic [7:0] sig_byte(input logic [1:0] k);
        logic [7:0] s;
        case (k)
            2'h0: s = EX_SIG_B0;
            2'h1: s = EX_SIG_B1;
            2'h2: s = EX_SIG_B2;
            default: s = EX_SIG_B3;
        endcase
        return s;
    endfunction

    ppcc_state_t state_reg, state_next;
    logic [IDX_W-1:0] idx_reg;
    logic [1:0] copy_reg;
    logic ext_reg;
    logic [15:0] stored_crc_reg;
    logic [7:0] warm_raw_reg;
    logic [15:0] ddr3_raw_reg;
    logic [7:0] ddr2_raw_reg;
    logic stop_reg;
    logic [7:0] last_type_reg;
    logic order_err_reg;
    logic len_err_reg;
    logic [11:0] total_reg;
    logic [IDX_W-1:0] end_reg;
    logic [2:0] sig_cnt_reg;
    logic [3:0] nsect_reg;
    logic has_spec_reg;
    logic has_ecc_reg;
    logic ready_reg;
    ppcc_result_t result_reg;
    ppcc_caps_t caps_reg;
    ppcc_ext_t ext_reg_o;
    logic [15:0] crc_val;

    // Decoding
    wire logic take = (state_reg == ST_RUN) && byte_valid_i;
    wire logic start_ok = start_i && ((state_reg == ST_IDLE) || (state_reg == ST_DONE));
    wire logic is_pair = ext_reg && (idx_reg >= EX_PAIR_FIRST) && (idx_reg <= EX_PAIR_LAST);
    wire logic is_type = is_pair && !idx_reg[0];
    wire logic is_len = is_pair && idx_reg[0];
    wire logic is_sig = ext_reg && (idx_reg >= EX_SIG_FIRST) && (idx_reg <= EX_SIG_LAST);
    wire logic [1:0] sig_pos = 2'(idx_reg - EX_SIG_FIRST);
    wire logic sig_hit = is_sig && (byte_data_i == sig_byte(sig_pos));
    wire logic [11:0] total_next = total_reg + ((is_len && !stop_reg) ? {4'h0, byte_data_i} : 12'h000);
    wire logic [IDX_W-1:0] end_w = (idx_reg == EX_PAIR_LAST)
        ? EX_PAIR_LAST + IDX_W'({total_next, EX_UNIT_SHIFT'(0)}) : end_reg;
    wire logic last_byte = ext_reg ? ((idx_reg >= EX_PAIR_LAST) && (idx_reg == end_w)) : (idx_reg == PG_CRC_HI);
    wire logic crc_take = ext_reg ? (idx_reg >= EX_SIG_FIRST) : (idx_reg <= PG_CRC_LAST);
    wire logic crc_pass = (crc_val == stored_crc_reg);
    wire logic more_copies = !ext_reg && ({30'h0, copy_reg} < MAX_COPIES - 1);
    wire logic retry = (state_reg == ST_CHECK) && !crc_pass && more_copies;
    wire logic crc_init = start_ok || retry;

    // Capability decode from the copy under test
    wire logic [15:0] ddr3_modes = {ddr3_raw_reg[12:1], {4{ddr3_raw_reg[0]}}};
    wire logic [15:0] ddr2_vec = {13'h0000, ddr2_raw_reg[2:0]};
    wire ppcc_caps_t caps_w = '{
        warm_out: warm_raw_reg[3:0],
        warm_in: warm_raw_reg[7:4],
        ddr3_modes: ddr3_modes,
        ddr2_modes: ddr2_raw_reg[2:0],
        ddr3_rsvd_err: |ddr3_raw_reg[15:13],
        ddr2_rsvd_err: |ddr2_raw_reg[7:3],
        ddr3_gap_err: has_gap(ddr3_raw_reg),
        ddr2_gap_err: has_gap(ddr2_vec),
        ddr3_none: ~|ddr3_raw_reg[12:0]
    };
    wire ppcc_ext_t ext_w = '{
        sig_ok: sig_cnt_reg >= EX_SIG_MIN,
        sect_count: nsect_reg,
        has_spec: has_spec_reg,
        has_ecc: has_ecc_reg,
        order_err: order_err_reg,
        len_err: len_err_reg,
        last_idx: end_reg
    };

    ppcc_crc_byte u_crc (
        .clk_sys_i(clk_sys_i),
        .nrst_i(nrst_i),
        .init_i(crc_init),
        .en_i(take && crc_take),
        .data_i(byte_data_i),
        .crc_o(crc_val)
    );

    // Bytes are refused while the CRC result is judged
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (start_ok) begin
                    state_next = ST_RUN;
                end
            end
            ST_RUN: begin
                if (take && last_byte) begin
                    state_next = ST_CHECK;
                end
            end
            ST_CHECK: begin
                state_next = retry ? ST_RUN : ST_DONE;
            end
            ST_DONE: begin
                if (start_ok) begin
                    state_next = ST_RUN;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            state_reg <= ST_IDLE;
            ready_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            ready_reg <= (state_next == ST_RUN);
        end
    end

    // Byte position and copy index; each copy is checked on its own bytes
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            idx_reg <= '0;
            copy_reg <= 2'h0;
            ext_reg <= 1'b0;
        end else if (start_ok) begin
            idx_reg <= '0;
            copy_reg <= 2'h0;
            ext_reg <= ext_mode_i;
        end else if (retry) begin
            idx_reg <= '0;
            copy_reg <= copy_reg + 2'h1;
        end else if (take) begin
            idx_reg <= idx_reg + IDX_W'(1);
        end
    end

    // Stored CRC, low byte first
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            stored_crc_reg <= 16'h0000;
        end else if (take && (idx_reg == (ext_reg ? EX_CRC_LO : PG_CRC_LO))) begin
            stored_crc_reg[7:0] <= byte_data_i;
        end else if (take && (idx_reg == (ext_reg ? EX_CRC_HI : PG_CRC_HI))) begin
            stored_crc_reg[15:8] <= byte_data_i;
        end
    end

    // Raw capability bytes of the copy under test
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            warm_raw_reg <= 8'h00;
            ddr3_raw_reg <= 16'h0000;
            ddr2_raw_reg <= 8'h00;
        end else if (take && !ext_reg) begin
            if (idx_reg == PG_WARMUP) begin
                warm_raw_reg <= byte_data_i;
            end
            if (idx_reg == PG_DDR3_LO) begin
                ddr3_raw_reg[7:0] <= byte_data_i;
            end
            if (idx_reg == PG_DDR3_HI) begin
                ddr3_raw_reg[15:8] <= byte_data_i;
            end
            if (idx_reg == PG_DDR2_EXT) begin
                ddr2_raw_reg <= byte_data_i;
            end
        end
    end

    // Section list walk; the first unused type ends it
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i || start_ok) begin
            stop_reg <= 1'b0;
            last_type_reg <= SECT_UNUSED;
            order_err_reg <= 1'b0;
            len_err_reg <= 1'b0;
            total_reg <= 12'h000;
            end_reg <= '0;
            sig_cnt_reg <= 3'h0;
            nsect_reg <= 4'h0;
            has_spec_reg <= 1'b0;
            has_ecc_reg <= 1'b0;
        end else if (take) begin
            if (sig_hit) begin
                sig_cnt_reg <= sig_cnt_reg + 3'h1;
            end
            if (is_type && !stop_reg) begin
                if (byte_data_i == SECT_UNUSED) begin
                    stop_reg <= 1'b1;
                end else begin
                    order_err_reg <= order_err_reg | (byte_data_i <= last_type_reg);
                    last_type_reg <= byte_data_i;
                    nsect_reg <= nsect_reg + 4'h1;
                    has_spec_reg <= has_spec_reg | (byte_data_i == SECT_SPEC);
                    has_ecc_reg <= has_ecc_reg | (byte_data_i == SECT_ECC);
                end
            end
            if (is_len && !stop_reg) begin
                total_reg <= total_next;
                len_err_reg <= len_err_reg | (byte_data_i == 8'h00);
            end
            if (idx_reg == EX_PAIR_LAST) begin
                end_reg <= end_w;
            end
        end
    end

    // Verdict; result holds until the next start, caps and ext until a later verdict loads them
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            result_reg <= '0;
            caps_reg <= '0;
            ext_reg_o <= '0;
        end else if (start_ok) begin
            result_reg <= '0;
        end else if ((state_reg == ST_CHECK) && !retry) begin
            result_reg.done <= 1'b1;
            result_reg.valid <= crc_pass;
            result_reg.error <= !crc_pass;
            result_reg.copy <= copy_reg;
            if (crc_pass && !ext_reg) begin
                caps_reg <= caps_w;
            end
            if (ext_reg) begin
                ext_reg_o <= ext_w;
            end
        end
    end

    assign byte_ready_o = ready_reg;
    assign result_o = result_reg;
    assign caps_o = caps_reg;
    assign ext_o = ext_reg_o;
endmodule // ppcc_checker
`default_nettype wire

// File: testbench/ppcc_checker_monitor.sv
// Port checks for the capability page checker
`default_nettype none
module ppcc_checker_monitor
    import ppcc_pkg::*;
#(
    parameter int MAX_COPIES = PG_COPIES
) (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic start_i,
    input wire logic ext_mode_i,
    input wire logic byte_valid_i,
    input wire logic [7:0] byte_data_i,
    input wire logic byte_ready_o,
    input wire ppcc_result_t result_o,
    input wire ppcc_caps_t caps_o,
    input wire ppcc_ext_t ext_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);
    // Copies examined in this run, so the reported index can be judged
    logic [1:0] falls_reg;
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i || result_o.done) begin
            falls_reg <= 2'h0;
        end else if ($fell(byte_ready_o)) begin
            falls_reg <= falls_reg + 2'h1;
        end
    end
    sequence verdict_s;
        ##1 result_o.done;
    endsequence
    sequence retry_s;
        ##1 !result_o.done ##1 byte_ready_o;
    endsequence
    copy_gap_a: assert property ($fell(byte_ready_o) |-> verdict_s or retry_s)
        else $error("ready gap after a copy is wrong");
    copy_index_a: assert property ($rose(result_o.done) |-> result_o.copy == falls_reg - 2'h1)
        else $error("copy index does not match copies examined");
    ready_cause_a: assert property ($rose(byte_ready_o) |-> $past(start_i) || $past(byte_ready_o, 3))
        else $error("ready rose without start or retry");
    start_clear_a: assert property (start_i && result_o.done |=> byte_ready_o && result_o == 5'h00)
        else $error("accepted start did not clear result");
    done_hold_a: assert property (result_o.done && !start_i |=> $stable(result_o))
        else $error("result changed without a start");
    verdict_excl_a: assert property (result_o.done |-> result_o.valid != result_o.error)
        else $error("valid and error not exclusive");
    caps_keep_a: assert property ($rose(result_o.done) && !result_o.valid |-> $stable(caps_o))
        else $error("capabilities changed on a failed check");
    low_modes_a: assert property (caps_o.ddr3_modes[3:0] == 4'h0 || caps_o.ddr3_modes[3:0] == 4'hf)
        else $error("modes 0 to 3 not reported together");
    no_modes_a: assert property (caps_o.ddr3_none |-> caps_o.ddr3_modes == 16'h0000)
        else $error("none flagged while modes are set");
    sect_end_a: assert property (ext_o.last_idx != 16'h0000 |-> ext_o.last_idx[3:0] == 4'hf)
        else $error("extended page end not on a 16 byte unit");
    reset_clear_a: assert property (disable iff (1'b0) !nrst_i |=> !byte_ready_o && result_o == 5'h00)
        else $error("outputs not cleared by reset");
endmodule // ppcc_checker_monitor
bind ppcc_checker ppcc_checker_monitor #(.MAX_COPIES(MAX_COPIES)) u_monitor (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .start_i(start_i),
    .ext_mode_i(ext_mode_i),
    .byte_valid_i(byte_valid_i),
    .byte_data_i(byte_data_i),
    .byte_ready_o(byte_ready_o),
    .result_o(result_o),
    .caps_o(caps_o),
    .ext_o(ext_o)
);
`default_nettype wire

// File: testbench/ppcc_target_model.sv
// Flash target model streaming stored page bytes
`default_nettype none
module ppcc_target_model (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic go_i,
    input wire logic slow_i,
    input wire logic [15:0] total_i,
    input wire logic ready_i,
    output logic valid_o,
    output logic [7:0] data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Stored copies, never a replay of the first
    logic [7:0] mem [0:767]; // Three copies, none offered beyond
    logic [15:0] idx_reg;
    logic active_reg;
    logic gap_reg;
    logic take;
    assign take = valid_o && ready_i;
    // Lowest byte first, offer held until taken
    assign valid_o = active_reg && !gap_reg;
    // Idle data is the inverted low index byte, not a stored byte
    assign data_o = valid_o ? mem[idx_reg] : ~idx_reg[7:0];
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            idx_reg <= 16'h0000;
            active_reg <= 1'b0;
            gap_reg <= 1'b0;
        end else if (go_i) begin
            idx_reg <= 16'h0000;
            active_reg <= 1'b1;
            gap_reg <= 1'b0;
        end else begin
            gap_reg <= slow_i && take;
            if (take) begin
                idx_reg <= idx_reg + 16'h0001;
                active_reg <= idx_reg != total_i - 16'h0001;
            end
        end
    end
endmodule // ppcc_target_model
`default_nettype wire

// File: testbench/ppcc_checker_tb.sv
// Testbench for the capability page checker
`default_nettype none
module ppcc_checker_tb
    import ppcc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_i = 1'b0;
    logic nrst_i = 1'b0;
    logic start_i = 1'b0;
    logic ext_mode_i = 1'b0;
    logic go = 1'b0;
    logic slow = 1'b0;
    logic [15:0] total = 16'h0300;
    logic byte_valid_i;
    logic [7:0] byte_data_i;
    logic byte_ready_o;
    ppcc_result_t result_o;
    ppcc_caps_t caps_o;
    ppcc_ext_t ext_o;
    int errors = 0;
    int n_checks = 0;
    always #10 clk_sys_i = ~clk_sys_i;
    ppcc_checker dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .start_i(start_i), .ext_mode_i(ext_mode_i),
        .byte_valid_i(byte_valid_i), .byte_data_i(byte_data_i), .byte_ready_o(byte_ready_o),
        .result_o(result_o), .caps_o(caps_o), .ext_o(ext_o));
    ppcc_target_model model (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .go_i(go), .slow_i(slow),
        .total_i(total), .ready_i(byte_ready_o), .valid_o(byte_valid_i), .data_o(byte_data_i));
    task automatic summarize();
        if (errors == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Own MSB-first engine, kept apart from the design's
    task automatic seal(input int first, input int last, input int at);
        logic [15:0] c;
        c = CRC_INIT;
        for (int i = first; i <= last; i++) begin
            for (int b = 7; b >= 0; b--) begin
                c = {c[14:0], 1'b0} ^ ((c[15] ^ model.mem[i][b]) ? CRC_POLY : 16'h0000);
            end
        end
        model.mem[at] = c[7:0];
        model.mem[at + 1] = c[15:8];
    endtask
    // Warmup counts are written to byte 159 of each copy and read back
    // Bad copy 0 breaks the last covered byte, bad copy 1 the stored MSB
    task automatic build_page(input logic [7:0] warm, input logic [15:0] ddr3, input logic [7:0] ddr2,
        input logic [2:0] bad);
        for (int k = 0; k < 3; k++) begin
            for (int i = 0; i < 254; i++) begin
                model.mem[256 * k + i] = 8'(i * 7 + 3);
            end
            model.mem[256 * k + 159] = warm;
            model.mem[256 * k + 160] = ddr3[7:0];
            model.mem[256 * k + 161] = ddr3[15:8];
            model.mem[256 * k + 162] = ddr2;
            seal(256 * k, 256 * k + 253, 256 * k + 254);
            if (bad[k]) begin
                model.mem[256 * k + (k == 1 ? 255 : 253)] ^= 8'h01;
            end
        end
    endtask
    task automatic build_ext(input logic [31:0] sig, input logic [31:0] pairs, input int last);
        for (int i = 0; i < 768; i++) begin
            model.mem[i] = (i < 32) ? 8'h00 : 8'(i);
        end
        for (int i = 0; i < 4; i++) begin
            model.mem[2 + i] = sig[8 * i +: 8];
            model.mem[16 + i] = pairs[8 * i +: 8];
        end
        seal(2, last, 0);
    endtask
    task automatic run(input logic ext, input logic [15:0] len, input logic stall);
        @(posedge clk_sys_i);
        start_i <= 1'b1;
        ext_mode_i <= ext;
        go <= 1'b1;
        total <= len; // Byte counts on a byte-wide target
        slow <= stall;
        @(posedge clk_sys_i);
        start_i <= 1'b0;
        go <= 1'b0;
        for (int t = 0; t < 4000; t++) begin
            @(posedge clk_sys_i);
            #1;
            if (result_o.done === 1'b1) begin
                return;
            end
        end
        chk("done", 32'h1, 32'h0);
        summarize();
    endtask
    initial begin
        repeat (20) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        #1;
        chk("ready", 32'h0, 32'(byte_ready_o));
        chk("result", 32'h0, 32'(result_o));
        build_page(8'h53, 16'h001f, 8'h03, 3'b000);
        run(1'b0, 16'd768, 1'b0);
        chk("result", 32'h18, 32'(result_o));
        chk("warm", 32'h53, 32'({caps_o.warm_in, caps_o.warm_out}));
        chk("ddr3", 32'h00ff, 32'(caps_o.ddr3_modes));
        chk("ddr2", 32'h3, 32'(caps_o.ddr2_modes));
        chk("flags", 32'h0, 32'(caps_o[4:0]));
        build_page(8'h00, 16'h0000, 8'h00, 3'b001);
        run(1'b0, 16'd768, 1'b1);
        chk("result", 32'h19, 32'(result_o));
        chk("warm", 32'h0, 32'({caps_o.warm_in, caps_o.warm_out}));
        chk("flags", 32'h01, 32'(caps_o[4:0]));
        build_page(8'h21, 16'he005, 8'h0d, 3'b011);
        run(1'b0, 16'd768, 1'b0);
        chk("result", 32'h1a, 32'(result_o));
        chk("ddr3", 32'h002f, 32'(caps_o.ddr3_modes));
        chk("ddr2", 32'h5, 32'(caps_o.ddr2_modes));
        chk("flags", 32'h1e, 32'(caps_o[4:0]));
        build_page(8'h77, 16'h0001, 8'h00, 3'b111);
        run(1'b0, 16'd768, 1'b0);
        chk("result", 32'h16, 32'(result_o));
        chk("ddr3", 32'h002f, 32'(caps_o.ddr3_modes));
        build_ext(32'h00005045, 32'h02020101, 79);
        run(1'b1, 16'd80, 1'b1);
        chk("result", 32'h18, 32'(result_o));
        chk("ext", {7'h0, 1'b1, 4'd2, 4'b1100, 16'd79}, 32'(ext_o));
        build_ext(32'h00000045, 32'h00010102, 47);
        model.mem[40] ^= 8'h01;
        run(1'b1, 16'd48, 1'b0);
        chk("verdict", 32'h5, 32'(result_o[4:2]));
        chk("ext", {7'h0, 1'b0, 4'd2, 4'b1111, 16'd47}, 32'(ext_o));
        summarize();
    end
endmodule // ppcc_checker_tb
`default_nettype wire
